// ### include/tims_pkg.sv
// Package of constants and types for the transmit input mode selector
//==============================================================
package tims_pkg;
	localparam int CLK_PERIOD_NS  = 100;
	localparam int RZ_HOLD_NS     = 12000;
	localparam int RZ_HOLD_CYC    = (RZ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOW_HOLD_CYC   = RZ_HOLD_CYC;
	localparam int UNI_SEL_CYC    = 16;
	localparam int WORD_W         = 2;
	localparam int FIFO_DEPTH     = 8;

	typedef enum logic [1:0] {
		TIMS_BIPOLAR  = 2'h0,
		TIMS_UNIPOLAR = 2'h1,
		TIMS_RZ       = 2'h2,
		TIMS_OFF      = 2'h3
	} tims_mode_t;

	// Line symbol pair: tip and ring drive levels
	typedef struct packed {
		logic tip;
		logic ring;
	} tims_sym_t;
endpackage : tims_pkg

// ### verilog/tims_top.sv
// Transmit input mode selector with symbol FIFO
`timescale 1ns/1ps
`default_nettype none

//==============================================================
// Symbol FIFO
module tims_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             en_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             wr;
	logic             rd;

	assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem[rp_r];
	assign wr = en_i && in_valid_i && in_ready_o;
	assign rd = en_i && out_valid_o && out_ready_i;

	// Storage
	always_ff @(posedge clk_i) begin
		if (wr) begin
			mem[wp_r] <= in_data_i;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (wr) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (rd) begin
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule : tims_fifo

//==============================================================
// Top: pin sampling, mode selection, line output
module tims_top #(
	parameter int HOLD_CYC = tims_pkg::RZ_HOLD_CYC,
	parameter int SEL_CYC  = tims_pkg::UNI_SEL_CYC
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic en_i,
	input  wire logic ref_clk_present_i,
	input  wire logic tx_bit_clock_in_i,
	input  wire logic pos_mark_in_i,
	input  wire logic neg_mark_in_i,
	input  wire logic line_ready_i,
	output logic      line_tip_out_o,
	output logic      line_ring_out_o,
	output logic      line_oe_o,
	output logic      line_valid_o,
	output logic      sample_stall_o,
	output logic [1:0] mode_o
);
	logic [3:0] m1_r;
	logic [3:0] m2_r;
	logic       clk_d_r;
	logic [15:0] hi_cnt_r;
	logic [15:0] lo_cnt_r;
	logic [7:0]  sel_cnt_r;
	logic        uni_r;
	tims_pkg::tims_mode_t mode_r;
	tims_pkg::tims_mode_t mode_nxt;
	logic        fall;
	logic        tx_bit_clock_in;
	logic        posi;
	logic        negi;
	logic        refp;
	tims_pkg::tims_sym_t sym_w;
	tims_pkg::tims_sym_t fifo_q;
	logic        fifo_vld;
	logic        fifo_rdy;
	logic        push;

	// Two-stage synchronisers for the reference, bit clock and mark pins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			m1_r <= 4'h0;
			m2_r <= 4'h0;
		end else if (en_i) begin
			m1_r <= {ref_clk_present_i, tx_bit_clock_in_i, pos_mark_in_i, neg_mark_in_i};
			m2_r <= m1_r;
		end
	end
	assign refp = m2_r[3];
	assign tx_bit_clock_in = m2_r[2];
	assign posi = m2_r[1];
	assign negi = m2_r[0];
	assign fall = clk_d_r && !tx_bit_clock_in;

	// Bit clock level duration counters
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clk_d_r  <= 1'b0;
			hi_cnt_r <= 16'h0000;
			lo_cnt_r <= 16'h0000;
		end else if (en_i) begin
			clk_d_r  <= tx_bit_clock_in;
			hi_cnt_r <= !tx_bit_clock_in ? 16'h0000 : (hi_cnt_r == 16'hffff ? hi_cnt_r : hi_cnt_r + 16'h0001);
			lo_cnt_r <= tx_bit_clock_in ? 16'h0000 : (lo_cnt_r == 16'hffff ? lo_cnt_r : lo_cnt_r + 16'h0001);
		end
	end

	// Unipolar select: counts falling edges with select high
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel_cnt_r <= 8'h00;
			uni_r     <= 1'b0;
		end else if (en_i) begin
			if (!negi || !refp) begin
				sel_cnt_r <= 8'h00;
				uni_r     <= 1'b0;
			end else if (fall) begin
				// Count holds falls already seen, so this fall is the seventeenth
				if (sel_cnt_r >= 8'(SEL_CYC)) begin
					uni_r <= 1'b1;
				end else begin
					sel_cnt_r <= sel_cnt_r + 8'h01;
				end
			end
		end
	end

	// Mode decision
	always_comb begin
		mode_nxt = mode_r;
		if (!refp && tx_bit_clock_in && hi_cnt_r >= 16'(HOLD_CYC)) begin
			mode_nxt = tims_pkg::TIMS_RZ;
		end else if (!tx_bit_clock_in && lo_cnt_r >= 16'(HOLD_CYC)) begin
			mode_nxt = tims_pkg::TIMS_OFF;
		end else if (tx_bit_clock_in && mode_r == tims_pkg::TIMS_RZ && !refp) begin
			mode_nxt = tims_pkg::TIMS_RZ;
		end else if (fall || mode_r == tims_pkg::TIMS_RZ || mode_r == tims_pkg::TIMS_OFF) begin
			mode_nxt = uni_r ? tims_pkg::TIMS_UNIPOLAR : tims_pkg::TIMS_BIPOLAR;
			if (!fall) begin
				mode_nxt = mode_r == tims_pkg::TIMS_RZ ? tims_pkg::TIMS_BIPOLAR : mode_r;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_r <= tims_pkg::TIMS_OFF;
		end else if (en_i) begin
			mode_r <= mode_nxt;
		end
	end

	// Symbol formed for each falling edge in bipolar and unipolar modes
	always_comb begin
		sym_w.tip  = 1'b0;
		sym_w.ring = 1'b0;
		case (mode_r)
			tims_pkg::TIMS_UNIPOLAR: begin
				sym_w.tip = posi;
			end
			default: begin
				sym_w.tip  = posi && !negi;
				sym_w.ring = negi && !posi;
			end
		endcase
	end
	assign push = fall && (mode_r == tims_pkg::TIMS_BIPOLAR || mode_r == tims_pkg::TIMS_UNIPOLAR);

	tims_fifo #(.WIDTH(tims_pkg::WORD_W), .DEPTH(tims_pkg::FIFO_DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.en_i        (en_i),
		.in_data_i   (sym_w),
		.in_valid_i  (push),
		.in_ready_o  (fifo_rdy),
		.out_data_o  (fifo_q),
		.out_valid_o (fifo_vld),
		.out_ready_i (line_ready_i)
	);

	// Registered line outputs
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			line_tip_out_o  <= 1'b0;
			line_ring_out_o <= 1'b0;
			line_oe_o       <= 1'b0;
			line_valid_o    <= 1'b0;
			sample_stall_o  <= 1'b0;
			mode_o          <= 2'h3;
		end else if (en_i) begin
			mode_o         <= mode_r;
			sample_stall_o <= !fifo_rdy;
			case (mode_r)
				tims_pkg::TIMS_RZ: begin
					line_tip_out_o  <= posi;
					line_ring_out_o <= negi;
					line_oe_o       <= 1'b1;
					line_valid_o    <= 1'b1;
				end
				tims_pkg::TIMS_OFF: begin
					line_tip_out_o  <= 1'b0;
					line_ring_out_o <= 1'b0;
					line_oe_o       <= 1'b0;
					line_valid_o    <= 1'b0;
				end
				default: begin
					line_oe_o    <= 1'b1;
					line_valid_o <= fifo_vld && line_ready_i;
					if (fifo_vld && line_ready_i) begin
						line_tip_out_o  <= fifo_q.tip;
						line_ring_out_o <= fifo_q.ring;
					end
				end
			endcase
		end
	end

	// Checks
	a_off_no_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && mode_r == tims_pkg::TIMS_OFF |=> !line_oe_o) else $error("driver on while off");
	a_rz_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && mode_r == tims_pkg::TIMS_RZ |=> line_tip_out_o == $past(posi) && line_ring_out_o == $past(negi))
		else $error("rz output does not follow input");
	a_rz_needs_ref: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && mode_nxt == tims_pkg::TIMS_RZ && mode_r != tims_pkg::TIMS_RZ |-> !refp && tx_bit_clock_in)
		else $error("rz entered with reference present");
	a_rz_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && mode_nxt == tims_pkg::TIMS_RZ && mode_r != tims_pkg::TIMS_RZ |-> hi_cnt_r >= 16'(HOLD_CYC))
		else $error("rz entered too early");
	a_bip_map: assert property (@(posedge clk_i) disable iff (!nrst_i)
		push && mode_r == tims_pkg::TIMS_BIPOLAR |-> !(sym_w.tip && sym_w.ring)
		&& sym_w.tip == (posi && !negi) && sym_w.ring == (negi && !posi))
		else $error("bipolar mapping wrong");
	a_bip_sample: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && push |-> $past(tx_bit_clock_in) && !tx_bit_clock_in) else $error("sample off falling edge");
	a_uni_map: assert property (@(posedge clk_i) disable iff (!nrst_i)
		push && mode_r == tims_pkg::TIMS_UNIPOLAR |-> sym_w.tip == posi && !sym_w.ring)
		else $error("unipolar mapping wrong");
	a_uni_enter: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && !uni_r ##1 uni_r |-> $past(sel_cnt_r) >= 8'(SEL_CYC) && $past(refp) && $past(negi))
		else $error("unipolar entered early");
	a_uni_leave: assert property (@(posedge clk_i) disable iff (!nrst_i)
		en_i && !negi |=> !uni_r && sel_cnt_r == 8'h00) else $error("select low not honoured");
endmodule : tims_top

`default_nettype wire

// ### sim/tims_framer.sv
// Framer model: bit clock and data source for the mode selector
`timescale 1ns/1ps
`default_nettype none

//==============================================================
// Framer model
module tims_framer (
	input  wire logic [1:0] cmd_i,
	input  wire logic [1:0] sym_i,
	output logic            bclk_o,
	output logic            pos_o,
	output logic            neg_o
);
	logic [1:0] held_r;

	// Bit clock runs at 800 ns, or stands high or low on command
	initial begin
		bclk_o = 1'b0;
		#37;
		forever begin
			#400;
			if (cmd_i == 2'h1) begin
				bclk_o = ~bclk_o;
			end else begin
				bclk_o = cmd_i[1];
			end
		end
	end

	// Data changes on the rise so it is steady at the fall
	always @(posedge bclk_o) begin
		held_r <= sym_i;
	end

	// Pulses pass straight through while the clock stands high on command 2; command 3 holds the data latched at the rise
	assign {pos_o, neg_o} = (cmd_i == 2'h2) ? sym_i : held_r;
endmodule : tims_framer

`default_nettype wire

// ### sim/test_tims_top.sv
// Testbench of the transmit input mode selector
`timescale 1ns/1ps
`default_nettype none

module test_tims_top;
	localparam int HOLD = tims_pkg::RZ_HOLD_CYC;
	logic       clk_i      = 1'b0;
	logic       en         = 1'b1;
	logic       nrst_i     = 1'b0;
	logic       ref_ok     = 1'b1;
	logic       line_ready = 1'b1;
	logic [1:0] cmd        = 2'h1;
	logic [1:0] sym        = 2'h0;
	logic       bclk, pos, neg, tip, ring, oe, valid, stall;
	logic [1:0] mode;
	int         n_fail     = 0;
	int         checked    = 0;
	int         cyc        = 0;

	always #50 clk_i = ~clk_i;

	tims_framer u_tims_framer (.cmd_i(cmd), .sym_i(sym), .bclk_o(bclk), .pos_o(pos), .neg_o(neg));

	tims_top #(.HOLD_CYC(HOLD), .SEL_CYC(tims_pkg::UNI_SEL_CYC)) u_tims_top (
		.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .ref_clk_present_i(ref_ok),
		.tx_bit_clock_in_i(bclk), .pos_mark_in_i(pos), .neg_mark_in_i(neg),
		.line_ready_i(line_ready), .line_tip_out_o(tip), .line_ring_out_o(ring),
		.line_oe_o(oe), .line_valid_o(valid), .sample_stall_o(stall), .mode_o(mode)
	);

	//==============================================================
	// Shared tasks
	task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask : chk

	task automatic wait_pop();
		int i;
		for (i = 0; i < 40 && valid !== 1'b1; i++) @(negedge clk_i);
		chk({1'b0, valid}, 2'h1);
	endtask : wait_pop

	task automatic print_verdict();
		if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	//==============================================================
	// Scenarios
	task automatic t_bipolar();
		int k;
		for (k = 0; k < 4; k++) begin
			sym = k[1:0];
			repeat (24) @(negedge clk_i);
			wait_pop();
			chk({tip, ring}, {k == 2, k == 1});
			chk(mode, 2'h0);
		end
	endtask : t_bipolar

	task automatic t_unipolar();
		// Select low first so the fall count starts from zero
		sym = 2'h0;
		repeat (16) @(negedge clk_i);
		sym = 2'h1;
		repeat (8 * 14) @(negedge clk_i);
		chk(mode, 2'h0);
		repeat (8 * 6) @(negedge clk_i);
		chk(mode, 2'h1);
		sym = 2'h3;
		repeat (24) @(negedge clk_i);
		wait_pop();
		chk({tip, ring}, 2'h2);
		sym = 2'h0;
		repeat (24) @(negedge clk_i);
		chk(mode, 2'h0);
	endtask : t_unipolar

	task automatic t_rz();
		int i;
		logic [7:0] w;
		ref_ok = 1'b0;
		cmd = 2'h2;
		// Clock high for less than the hold time must not enter RZ
		repeat (HOLD - 10) @(negedge clk_i);
		chk(mode, 2'h0);
		repeat (30) @(negedge clk_i);
		chk(mode, 2'h2);
		chk({1'b0, oe}, 2'h1);
		w = 8'h00;
		for (i = 0; i < 14; i++) begin
			sym = (i < 3) ? 2'h2 : 2'h0;
			@(negedge clk_i);
			w = w + 8'(tip);
		end
		chk({1'b0, w === 8'h03}, 2'h1);
		ref_ok = 1'b1;
	endtask : t_rz

	task automatic t_off();
		cmd = 2'h0;
		repeat (HOLD + 20) @(negedge clk_i);
		chk({1'b0, oe}, 2'h0);
		chk(mode, 2'h3);
		// Enable low freezes everything, even with the clock running again
		en = 1'b0;
		cmd = 2'h1;
		repeat (40) @(negedge clk_i);
		chk(mode, 2'h3);
		chk({1'b0, oe}, 2'h0);
		en = 1'b1;
		repeat (40) @(negedge clk_i);
		chk(mode, 2'h0);
	endtask : t_off

	task automatic t_fifo();
		line_ready = 1'b0;
		repeat (8 * 12) @(negedge clk_i);
		chk({1'b0, stall}, 2'h1);
		chk({1'b0, valid}, 2'h0);
		line_ready = 1'b1;
		repeat (16) @(negedge clk_i);
		chk({1'b0, stall}, 2'h0);
	endtask : t_fifo

	// Cycle ceiling cuts a hang short
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 5000) begin
			n_fail++;
			print_verdict();
		end
	end

	// Main sequence
	initial begin
		repeat (8) @(negedge clk_i);
		nrst_i = 1'b1;
		repeat (40) @(negedge clk_i);
		t_bipolar();
		t_unipolar();
		t_rz();
		t_off();
		t_fifo();
		print_verdict();
	end
endmodule : test_tims_top

`default_nettype wire
